/* File: include/can_filt_pkg.sv */
// package: register map, fields, reset values and carriers for the receive filter routing block
// Notes on behaviour
// - legacy mode forces the length count to zero, writes ignored
// - data-byte filter up to eighteen bits from filter extended identifier bits
// - compared bit count depends on the received frame length code
// - length code zero compares no data bits
// - length code one compares up to seven bits, count from three low bits
// - length code two compares up to fifteen bits, count from four low bits
// - length code three compares up to eighteen bits, count from all five bits
// - length count in five low bits, upper three read zero
// - sixteen four-bit buffer pointers, even filter low nibble, odd high nibble
// - pointer zero routes to first receive buffer, one to second
// - pointers two to seven route to programmable buffers zero to five
// - two-bit mask selector: zero uses mask zero, one uses mask one
// - selector two uses filter fifteen as mask, three applies no mask
// - selectors packed four per byte, lowest filter in bits one and zero
// - these registers exist only in enhanced and fifo modes
package can_filt_pkg;
  localparam int NUM_FILT = 16;
  localparam int DATA_FILT_BITS = 18;
  localparam logic [7:0] OFS_LEN = 8'h00;
  localparam logic [7:0] OFS_PTR0 = 8'h01;
  localparam logic [7:0] OFS_MASK_SELECT_0 = 8'h09;
  localparam int NUM_PTR_REGS = 8;
  localparam int NUM_MSEL_REGS = 4;
  localparam logic [7:0] OFS_MODE = 8'h0d;
  localparam logic [7:0] OFS_STAT = 8'h0e;
  localparam int LEN_W = 5;
  localparam logic [4:0] LEN_RST = 5'h00;
  localparam logic [4:0] LEN_LEGACY = 5'h00;
  localparam logic [63:0] PTR_RST = 64'h0000_0000_0011_1100;
  localparam logic [31:0] MSEL_RST = 32'h0000_0550;
  localparam logic [3:0] PTR_RSVD_MIN = 4'h8;
  localparam logic [3:0] PTR_PROG_BASE = 4'h2;
  typedef enum logic [1:0] {MODE_LEGACY = 2'h0, MODE_ENH = 2'h1, MODE_FIFO = 2'h2} op_mode_t;
  typedef enum logic [1:0] {SEL_MASK0 = 2'h0, SEL_MASK1 = 2'h1, SEL_FILT15 = 2'h2, SEL_NONE = 2'h3} msel_t;
  typedef enum logic [1:0] {DEST_RXB = 2'h0, DEST_PROG = 2'h1, DEST_BAD = 2'h2} dest_kind_t;
  typedef struct packed {
    logic valid;
    logic [3:0] hit;
    logic [3:0] lengthCode;
    logic [17:0] dataBits;
  } frame_t;
  typedef struct packed {
    dest_kind_t kind;
    logic [2:0] index;
  } route_t;
endpackage

/* File: core/cfg_byte_mem.sv */
`timescale 1ns/1ps
// cfg_byte_mem: small byte register file with registered read data
module cfg_byte_mem #(
  parameter int DEPTH = 12,
  parameter int AW = 4,
  parameter logic [DEPTH*8-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData,
  output logic [DEPTH*8-1:0] flat
);
  logic [DEPTH*8-1:0] mem_r;
  logic [DEPTH*8-1:0] mem_nxt;
  logic [7:0] rdData_nxt;
  // whole contents exposed flat: routing needs every entry at once
  always_comb
  begin
    mem_nxt = mem_r;
    if (wrEn && (int'(wrAddr) < DEPTH))
    begin
      mem_nxt[wrAddr*8 +: 8] = wrData;
    end
    rdData_nxt = (int'(rdAddr) < DEPTH) ? mem_r[rdAddr*8 +: 8] : 8'h00;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mem_r <= INIT;
      rdData <= 8'h00;
    end
    else
    begin
      mem_r <= mem_nxt;
      rdData <= rdData_nxt;
    end
  end
  assign flat = mem_r;
endmodule

/* File: core/data_len_mask.sv */
`timescale 1ns/1ps
// data_len_mask: which data bits take part in the data-byte compare
module data_len_mask (
  input wire logic [3:0] lengthCode,
  input wire logic [4:0] lengthCount,
  output logic [17:0] cmpEnable
);
  logic [4:0] n;
  // count cut to its low bits for codes one and two, clamped at eighteen for three, so short frames never compare absent bytes
  always_comb
  begin
    n = 5'h00;
    case (lengthCode)
      4'h0: n = 5'h00;
      4'h1: n = (lengthCount[2:0] == 3'h0) ? 5'h00 : {2'h0, lengthCount[2:0]};
      4'h2: n = {1'h0, lengthCount[3:0]};
      default: n = (lengthCount > 5'h12) ? 5'h12 : lengthCount;
    endcase
    for (int i = 0; i < 18; i++)
    begin
      cmpEnable[i] = (i < int'(n));
    end
  end
endmodule

/* File: core/can_rx_filter_routing.sv */
`timescale 1ns/1ps
// can_rx_filter_routing: filter length, buffer pointers and mask selection for sixteen receive filters
module can_rx_filter_routing (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic configMode,
  input wire can_filt_pkg::frame_t frameIn,
  input wire logic [17:0] filtIdBits [16],
  input wire logic [17:0] mask0Bits,
  input wire logic [17:0] mask1Bits,
  output can_filt_pkg::route_t routeOut,
  output logic dataMatch,
  output logic [17:0] effMask,
  output logic routeValid
);
  localparam int NREG = can_filt_pkg::NUM_PTR_REGS + can_filt_pkg::NUM_MSEL_REGS;
  can_filt_pkg::op_mode_t mode_r;
  can_filt_pkg::op_mode_t mode_nxt;
  logic [4:0] len_r;
  logic [4:0] len_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;
  logic rdMem_r;
  logic rdMem_nxt;
  logic rsvdSeen_r;
  logic rsvdSeen_nxt;
  logic legacy;
  logic inMem;
  logic [3:0] memIdx;
  logic memWr;
  logic [7:0] memRd;
  logic [NREG*8-1:0] flat;
  logic [3:0] ptr [16];
  logic [1:0] sel [16];
  logic [17:0] cmpEn;
  can_filt_pkg::route_t route_nxt;
  logic match_nxt;
  logic [17:0] mask_nxt;
  logic [3:0] p;
  logic [1:0] s;
  assign legacy = (mode_r == can_filt_pkg::MODE_LEGACY);
  assign inMem = (regAddr >= can_filt_pkg::OFS_PTR0) && (regAddr < can_filt_pkg::OFS_MODE);
  assign memIdx = 4'(regAddr - can_filt_pkg::OFS_PTR0);
  // writes only land outside legacy mode and while configuring
  assign memWr = regWr && inMem && !legacy && configMode;
  cfg_byte_mem #(
    .DEPTH(NREG),
    .AW(4),
    .INIT({can_filt_pkg::MSEL_RST, can_filt_pkg::PTR_RST})
  ) u_cfg (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(memWr),
    .wrAddr(memIdx),
    .wrData(regWdata),
    .rdAddr(memIdx),
    .rdData(memRd),
    .flat(flat)
  );
  // unpack pointers and selectors per filter
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_unpack
      assign ptr[g] = flat[(g/2)*8 + (g%2)*4 +: 4];
      assign sel[g] = flat[can_filt_pkg::NUM_PTR_REGS*8 + (g/4)*8 + (g%4)*2 +: 2];
    end
  endgenerate
  data_len_mask u_len (
    .lengthCode(frameIn.lengthCode),
    .lengthCount(len_r),
    .cmpEnable(cmpEn)
  );
  // register file: length count, mode and status bits
  always_comb
  begin
    mode_nxt = mode_r;
    len_nxt = len_r;
    rsvdSeen_nxt = rsvdSeen_r;
    rdMem_nxt = regRd && inMem && !legacy;
    rd_nxt = 8'h00;
    if (regWr && regAddr == can_filt_pkg::OFS_MODE)
    begin
      case (regWdata[1:0])
        2'h1: mode_nxt = can_filt_pkg::MODE_ENH;
        2'h2: mode_nxt = can_filt_pkg::MODE_FIFO;
        default: mode_nxt = can_filt_pkg::MODE_LEGACY;
      endcase
    end
    if (regWr && regAddr == can_filt_pkg::OFS_LEN && configMode)
    begin
      len_nxt = regWdata[4:0];
    end
    if (legacy || mode_nxt == can_filt_pkg::MODE_LEGACY)
    begin
      len_nxt = can_filt_pkg::LEN_LEGACY;
    end
    // reserved pointer code seen on an accepted frame; sticky until status write
    if (regWr && regAddr == can_filt_pkg::OFS_STAT)
    begin
      rsvdSeen_nxt = 1'b0;
    end
    if (frameIn.valid && !legacy && ptr[frameIn.hit] >= can_filt_pkg::PTR_RSVD_MIN)
    begin
      rsvdSeen_nxt = 1'b1;
    end
    if (regRd)
    begin
      case (regAddr)
        can_filt_pkg::OFS_LEN: rd_nxt = {3'h0, len_r};
        can_filt_pkg::OFS_MODE: rd_nxt = {6'h00, mode_r};
        can_filt_pkg::OFS_STAT: rd_nxt = {7'h00, rsvdSeen_r};
        default: rd_nxt = 8'h00;
      endcase
      // pointer and selector bytes taken from the flat copy, so the read data leave a flop
      if (inMem && !legacy)
      begin
        rd_nxt = flat[int'(memIdx) * 8 +: 8];
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_r <= can_filt_pkg::MODE_LEGACY;
      len_r <= can_filt_pkg::LEN_RST;
      rsvdSeen_r <= 1'b0;
      rdMem_r <= 1'b0;
      rd_r <= 8'h00;
    end
    else
    begin
      mode_r <= mode_nxt;
      len_r <= len_nxt;
      rsvdSeen_r <= rsvdSeen_nxt;
      rdMem_r <= rdMem_nxt;
      rd_r <= rd_nxt;
    end
  end
  // read data leave a flop; legacy zeroing is settled when the strobe is taken
  assign regRdata = rd_r;
  // routing and data compare for the filter that hit
  always_comb
  begin
    p = ptr[frameIn.hit];
    s = sel[frameIn.hit];
    route_nxt.kind = can_filt_pkg::DEST_BAD;
    route_nxt.index = 3'h0;
    if (p < can_filt_pkg::PTR_PROG_BASE)
    begin
      route_nxt.kind = can_filt_pkg::DEST_RXB;
      route_nxt.index = {2'h0, p[0]};
    end
    else if (p < can_filt_pkg::PTR_RSVD_MIN)
    begin
      route_nxt.kind = can_filt_pkg::DEST_PROG;
      route_nxt.index = 3'(p - can_filt_pkg::PTR_PROG_BASE);
    end
    case (s)
      can_filt_pkg::SEL_MASK0: mask_nxt = mask0Bits;
      can_filt_pkg::SEL_MASK1: mask_nxt = mask1Bits;
      can_filt_pkg::SEL_FILT15: mask_nxt = filtIdBits[15];
      default: mask_nxt = 18'h00000;
    endcase
    if (legacy)
    begin
      mask_nxt = mask0Bits;
      route_nxt.kind = can_filt_pkg::DEST_RXB;
      route_nxt.index = 3'h0;
    end
    // only enabled bits whose mask bit is set must agree
    match_nxt = ((frameIn.dataBits ^ filtIdBits[frameIn.hit]) & cmpEn & mask_nxt) == 18'h00000;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      routeOut <= '0;
      dataMatch <= 1'b0;
      effMask <= 18'h00000;
      routeValid <= 1'b0;
    end
    else
    begin
      routeOut <= route_nxt;
      dataMatch <= match_nxt && frameIn.valid;
      effMask <= mask_nxt;
      routeValid <= frameIn.valid;
    end
  end
  property p_legacy_len;
    @(posedge clk) disable iff (sys_rst) legacy |-> len_r == 5'h00;
  endproperty
  a_legacy_len: assert property (p_legacy_len) else $error("length count not zero in legacy");
  property p_len_upper;
    @(posedge clk) disable iff (sys_rst) regRd && regAddr == can_filt_pkg::OFS_LEN |=> regRdata[7:5] == 3'h0;
  endproperty
  a_len_upper: assert property (p_len_upper) else $error("length upper bits not zero");
  property p_dlc0;
    @(posedge clk) disable iff (sys_rst) frameIn.valid && frameIn.lengthCode == 4'h0 |=> dataMatch;
  endproperty
  a_dlc0: assert property (p_dlc0) else $error("zero length code compared data");
  property p_dlc1;
    @(posedge clk) disable iff (sys_rst) frameIn.lengthCode == 4'h1 |-> cmpEn[17:8] == 10'h000;
  endproperty
  a_dlc1: assert property (p_dlc1) else $error("length code one compared above eight");
  property p_dlc2;
    @(posedge clk) disable iff (sys_rst) frameIn.lengthCode == 4'h2 |-> cmpEn[17:16] == 2'h0;
  endproperty
  a_dlc2: assert property (p_dlc2) else $error("length code two compared above sixteen");
  property p_dlc3;
    @(posedge clk) disable iff (sys_rst) frameIn.lengthCode == 4'h3 && len_r >= 5'h12 |-> &cmpEn;
  endproperty
  a_dlc3: assert property (p_dlc3) else $error("eighteen bits not compared");
  property p_route_rxb;
    @(posedge clk) disable iff (sys_rst) frameIn.valid && !legacy && ptr[frameIn.hit] == 4'h1
      |=> routeOut.kind == can_filt_pkg::DEST_RXB && routeOut.index == 3'h1;
  endproperty
  a_route_rxb: assert property (p_route_rxb) else $error("pointer one not to second buffer");
  property p_route_prog;
    @(posedge clk) disable iff (sys_rst) frameIn.valid && !legacy && ptr[frameIn.hit] == 4'h7
      |=> routeOut.kind == can_filt_pkg::DEST_PROG && routeOut.index == 3'h5;
  endproperty
  a_route_prog: assert property (p_route_prog) else $error("pointer seven not to last buffer");
  property p_f15_mask;
    @(posedge clk) disable iff (sys_rst) !legacy && sel[frameIn.hit] == 2'h2 |=> effMask == $past(filtIdBits[15]);
  endproperty
  a_f15_mask: assert property (p_f15_mask) else $error("filter fifteen not used as mask");
  property p_legacy_nowrite;
    @(posedge clk) disable iff (sys_rst) legacy && !memWr |=> $stable(flat);
  endproperty
  a_legacy_nowrite: assert property (p_legacy_nowrite) else $error("config changed in legacy mode");

  // register port, routing and mask checks; the memory port is kept as an independent copy

  property p_mem_port;
    @(posedge clk) disable iff (sys_rst) rdMem_r |-> regRdata == memRd;
  endproperty
  a_mem_port: assert property (p_mem_port) else $error("flat read differs from memory port");

  property p_legacy_rd_zero;
    @(posedge clk) disable iff (sys_rst) regRd && inMem && legacy |=> regRdata == 8'h00;
  endproperty
  a_legacy_rd_zero: assert property (p_legacy_rd_zero) else $error("config register visible in legacy");

  property p_legacy_route;
    @(posedge clk) disable iff (sys_rst) frameIn.valid && legacy
      |=> routeOut.kind == can_filt_pkg::DEST_RXB && routeOut.index == 3'h0;
  endproperty
  a_legacy_route: assert property (p_legacy_route) else $error("legacy frame not to first buffer");

  property p_route_rx_buffer_first;
    @(posedge clk) disable iff (sys_rst) frameIn.valid && !legacy && ptr[frameIn.hit] == 4'h0
      |=> routeOut.kind == can_filt_pkg::DEST_RXB && routeOut.index == 3'h0;
  endproperty
  a_route_rx_buffer_first: assert property (p_route_rx_buffer_first) else $error("pointer zero not to first buffer");

  property p_route_prog0;
    @(posedge clk) disable iff (sys_rst) frameIn.valid && !legacy && ptr[frameIn.hit] == 4'h2
      |=> routeOut.kind == can_filt_pkg::DEST_PROG && routeOut.index == 3'h0;
  endproperty
  a_route_prog0: assert property (p_route_prog0) else $error("pointer two not to first prog buffer");

  property p_mask0;
    @(posedge clk) disable iff (sys_rst) !legacy && sel[frameIn.hit] == 2'h0 |=> effMask == $past(mask0Bits);
  endproperty
  a_mask0: assert property (p_mask0) else $error("selector zero not using mask zero");

  property p_mask1;
    @(posedge clk) disable iff (sys_rst) !legacy && sel[frameIn.hit] == 2'h1 |=> effMask == $past(mask1Bits);
  endproperty
  a_mask1: assert property (p_mask1) else $error("selector one not using mask one");

  property p_nomask;
    @(posedge clk) disable iff (sys_rst) !legacy && sel[frameIn.hit] == 2'h3 |=> effMask == 18'h00000;
  endproperty
  a_nomask: assert property (p_nomask) else $error("selector three still applied a mask");

  property p_len_lock;
    @(posedge clk) disable iff (sys_rst) regWr && regAddr == can_filt_pkg::OFS_LEN && !configMode
      |=> $stable(len_r);
  endproperty
  a_len_lock: assert property (p_len_lock) else $error("length count written outside config");

  property p_cfg_lock;
    @(posedge clk) disable iff (sys_rst) regWr && inMem && !configMode |=> $stable(flat);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("pointer or selector written outside config");

  property p_len_write;
    @(posedge clk) disable iff (sys_rst) regWr && regAddr == can_filt_pkg::OFS_LEN && configMode && !legacy
      |=> len_r == $past(regWdata[4:0]);
  endproperty
  a_len_write: assert property (p_len_write) else $error("length count write lost");

  property p_mode_fifo;
    @(posedge clk) disable iff (sys_rst) regWr && regAddr == can_filt_pkg::OFS_MODE && regWdata[1:0] == 2'h2
      |=> mode_r == can_filt_pkg::MODE_FIFO;
  endproperty
  a_mode_fifo: assert property (p_mode_fifo) else $error("fifo mode not entered");

  property p_ptr_pair;
    @(posedge clk) disable iff (sys_rst) regWr && regAddr == can_filt_pkg::OFS_PTR0 && configMode && !legacy
      |=> ptr[0] == $past(regWdata[3:0]) && ptr[1] == $past(regWdata[7:4]);
  endproperty
  a_ptr_pair: assert property (p_ptr_pair) else $error("pointer nibbles not paired by filter");

  property p_sel_pack;
    @(posedge clk) disable iff (sys_rst) regWr && regAddr == can_filt_pkg::OFS_MASK_SELECT_0 && configMode && !legacy
      |=> sel[0] == $past(regWdata[1:0]) && sel[3] == $past(regWdata[7:6]);
  endproperty
  a_sel_pack: assert property (p_sel_pack) else $error("selectors not packed two bits per filter");

  property p_dlc0_none;
    @(posedge clk) disable iff (sys_rst) frameIn.lengthCode == 4'h0 |-> cmpEn == 18'h00000;
  endproperty
  a_dlc0_none: assert property (p_dlc0_none) else $error("zero length code enabled a bit");

  property p_dlc1_cap;
    @(posedge clk) disable iff (sys_rst) frameIn.lengthCode == 4'h1 |-> cmpEn[0] == (len_r[2:0] != 3'h0);
  endproperty
  a_dlc1_cap: assert property (p_dlc1_cap) else $error("length code one ignores low count bits");

  property p_dlc2_cap;
    @(posedge clk) disable iff (sys_rst) frameIn.lengthCode == 4'h2 |-> cmpEn[0] == (len_r[3:0] != 4'h0);
  endproperty
  a_dlc2_cap: assert property (p_dlc2_cap) else $error("length code two ignores low count bits");

  property p_dlc3_top;
    @(posedge clk) disable iff (sys_rst) frameIn.lengthCode == 4'h3 |-> cmpEn[17] == (len_r >= 5'h12);
  endproperty
  a_dlc3_top: assert property (p_dlc3_top) else $error("top data bit enable wrong");

  property p_valid_follow;
    @(posedge clk) disable iff (sys_rst) frameIn.valid |=> routeValid;
  endproperty
  a_valid_follow: assert property (p_valid_follow) else $error("frame produced no route");

  property p_match_clear;
    @(posedge clk) disable iff (sys_rst) !frameIn.valid |=> !dataMatch;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match without a frame");

  property p_rsvd_clear;
    @(posedge clk) disable iff (sys_rst) regWr && regAddr == can_filt_pkg::OFS_STAT && !frameIn.valid |=> !rsvdSeen_r;
  endproperty
  a_rsvd_clear: assert property (p_rsvd_clear) else $error("status write did not clear flag");
endmodule

/* File: dv/can_node_model.sv */
// can_node_model: bus node stand-in that hands received frames to the filter block
`timescale 1ns/1ps
module can_node_model (
  input wire logic clk,
  output can_filt_pkg::frame_t frameOut
);
  initial frameOut = '0;

  // one frame per call, valid for a single cycle; gap gives a slow node
  // payload lines flip once released so a stale frame never looks valid
  task automatic send(input logic [3:0] hit, input logic [3:0] code, input logic [17:0] data, input int gap);
    frameOut <= {1'b1, hit, code, data};
    @(posedge clk);
    frameOut.valid <= 1'b0;
    frameOut.dataBits <= ~data;
    repeat (gap + 1) @(posedge clk);
  endtask
endmodule

/* File: dv/testbench.sv */
// testbench: register access, routing and data filter checks for the receive filter routing block
`timescale 1ns/1ps
module testbench;
  typedef struct packed {can_filt_pkg::route_t r; logic [17:0] m; logic d;} expect_t;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic regWr = 1'b0, regRd = 1'b0, configMode = 1'b1, rdPend = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [7:0] ptrByte [8];
  logic [7:0] mselByte [4];
  logic [17:0] filtId [16];
  logic [17:0] mask0, mask1, effMask;
  logic dataMatch, routeValid;
  can_filt_pkg::frame_t frameIn;
  can_filt_pkg::route_t routeOut;
  expect_t expQ [$];
  logic [7:0] rdQ [$];
  logic [17:0] cases [7];
  int mismatches = 0, compares = 0, cycles = 0;

  always #10 clk = ~clk;

  can_node_model node (.clk(clk), .frameOut(frameIn));

  can_rx_filter_routing dut (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .configMode(configMode), .frameIn(frameIn),
    .filtIdBits(filtId), .mask0Bits(mask0), .mask1Bits(mask1), .routeOut(routeOut),
    .dataMatch(dataMatch), .effMask(effMask), .routeValid(routeValid));

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one strobe cycle, then an idle edge so a strobe is never set twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic frm(input logic [3:0] h, input logic [3:0] c, input logic [17:0] x, input expect_t e, input int g);
    expQ.push_back(e);
    node.send(h, c, filtId[h] ^ x, g);
  endtask

  function automatic can_filt_pkg::route_t dest(input logic [3:0] p);
    dest.kind = (p < can_filt_pkg::PTR_PROG_BASE) ? can_filt_pkg::DEST_RXB : can_filt_pkg::DEST_PROG;
    dest.index = (p < can_filt_pkg::PTR_PROG_BASE) ? p[2:0] : 3'(p - can_filt_pkg::PTR_PROG_BASE);
  endfunction

  function automatic logic [17:0] selMask(input logic [1:0] s);
    case (s)
      2'h0: selMask = mask0;
      2'h1: selMask = mask1;
      2'h2: selMask = filtId[15];
      default: selMask = 18'h00000;
    endcase
  endfunction

  // outputs are compared against the oldest note; a result with no note is a mismatch too
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      finish_test();
    end
    if (rdPend === 1'b1)
      check(rdQ.size() > 0 && regRdata === rdQ.pop_front(), "read data");
    if (routeValid === 1'b1)
      check(expQ.size() > 0 && {routeOut, effMask, dataMatch} === expQ.pop_front(), "frame result");
    rdPend <= regRd;
  end

  initial
  begin
    logic [2:0] r;
    logic [1:0] sr;
    logic [3:0] p;
    void'($urandom(33689));
    mask0 = 18'($urandom);
    mask1 = 18'($urandom);
    foreach (filtId[i]) filtId[i] = 18'($urandom);
    r = 3'($urandom);
    sr = 2'($urandom);
    cases = '{{8'h07, 4'h1, 5'd8, 1'b1}, {8'h07, 4'h1, 5'd0, 1'b0}, {8'h0f, 4'h2, 5'd16, 1'b1},
      {8'h0f, 4'h2, 5'd1, 1'b0}, {8'h1f, 4'h3, 5'd16, 1'b0}, {8'h1f, 4'h0, 5'd0, 1'b1}, {8'h00, 4'h1, 5'd0, 1'b1}};
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    // legacy mode: length held at zero, config registers absent, slow node
    wr(can_filt_pkg::OFS_LEN, 8'hff);
    rd(can_filt_pkg::OFS_LEN, 8'h00);
    rd(can_filt_pkg::OFS_PTR0 + 8'h01, 8'h00);
    frm(4'h5, 4'h3, 18'h3ffff, {can_filt_pkg::DEST_RXB, 3'h0, mask0, 1'b1}, 3);
    wr(can_filt_pkg::OFS_MODE, 8'h01);
    // reset values once enhanced mode is on, plus an unmapped place
    rd(can_filt_pkg::OFS_PTR0, 8'h00);
    rd(can_filt_pkg::OFS_PTR0 + 8'h01, 8'h11);
    rd(can_filt_pkg::OFS_PTR0 + 8'h02, 8'h11);
    rd(can_filt_pkg::OFS_MASK_SELECT_0, 8'h50);
    rd(can_filt_pkg::OFS_MASK_SELECT_0 + 8'h01, 8'h05);
    rd(8'hf0, 8'h00);
    wr(can_filt_pkg::OFS_LEN, 8'hff);
    rd(can_filt_pkg::OFS_LEN, 8'h1f);
    configMode <= 1'b0;
    wr(can_filt_pkg::OFS_LEN, 8'h00);
    rd(can_filt_pkg::OFS_LEN, 8'h1f);
    wr(can_filt_pkg::OFS_PTR0, 8'h77);
    rd(can_filt_pkg::OFS_PTR0, 8'h00);
    configMode <= 1'b1;
    // rotated codes so all eight pointer codes and four selector codes appear; codes stay below eight
    for (int k = 0; k < 8; k++)
    begin
      ptrByte[k] = {1'b0, 3'(2 * k + 1) + r, 1'b0, 3'(2 * k) + r};
      wr(can_filt_pkg::OFS_PTR0 + 8'(k), ptrByte[k]);
      rd(can_filt_pkg::OFS_PTR0 + 8'(k), ptrByte[k]);
    end
    for (int k = 0; k < 4; k++)
    begin
      mselByte[k] = 8'he4 ^ {4{sr}};
      wr(can_filt_pkg::OFS_MASK_SELECT_0 + 8'(k), mselByte[k]);
      rd(can_filt_pkg::OFS_MASK_SELECT_0 + 8'(k), mselByte[k]);
    end
    for (int f = 0; f < 16; f++)
    begin
      p = f[0] ? ptrByte[f / 2][7:4] : ptrByte[f / 2][3:0];
      frm(4'(f), 4'h0, 18'($urandom), {dest(p), selMask(mselByte[f / 4][2 * (f % 4) +: 2]), 1'b1}, f % 3);
    end
    // data compare through filter 0 with a full mask, one bit flipped per case
    // case layout: length byte [17:10], length code [9:6], flipped bit [5:1], expected match [0]
    mask0 <= 18'h3ffff;
    wr(can_filt_pkg::OFS_MASK_SELECT_0, mselByte[0] & 8'hfc);
    foreach (cases[i])
    begin
      wr(can_filt_pkg::OFS_LEN, cases[i][17:10]);
      frm(4'h0, cases[i][9:6], 18'h00001 << cases[i][5:1], {dest(ptrByte[0][3:0]), 18'h3ffff, cases[i][0]}, 0);
    end
    // status clear, fifo mode keeps the registers, code three falls back to legacy
    wr(can_filt_pkg::OFS_STAT, 8'h00);
    rd(can_filt_pkg::OFS_STAT, 8'h00);
    wr(can_filt_pkg::OFS_MODE, 8'h02);
    rd(can_filt_pkg::OFS_MODE, 8'h02);
    wr(can_filt_pkg::OFS_LEN, 8'h1f);
    rd(can_filt_pkg::OFS_LEN, 8'h1f);
    rd(can_filt_pkg::OFS_PTR0, ptrByte[0]);
    wr(can_filt_pkg::OFS_MODE, 8'h03);
    rd(can_filt_pkg::OFS_MODE, 8'h00);
    rd(can_filt_pkg::OFS_MASK_SELECT_0, 8'h00);
    rd(can_filt_pkg::OFS_LEN, 8'h00);
    repeat (4) @(posedge clk);
    check(expQ.size() == 0 && rdQ.size() == 0, "results missing");
    finish_test();
  end
endmodule
